// ===== hw/ces_seq.sv
// Notes on behaviour
// - direct mode address is zero high byte and the operand byte low
// - extended mode takes two program bytes, high byte first
// - indexed modes use index pair plus none, 8-bit or 16-bit offset
// - stack-relative modes use stack pointer plus 8-bit or 16-bit offset
// - no-offset post increment bumps index pair; move and compare-branch only
// - 8-bit-offset post increment bumps index pair; compare-branch only
// - any reset source aborts execution at once, no instruction boundary
// - reset ends only when source check is done and pin is released
// - reset end runs six cycles: vector high, low, then queue fill
// - interrupt is taken only after the current instruction completes
// - interrupt vector comes from highest pending request at sequence start
// - entry pushes pc low, pc high, index low, accumulator, condition codes
// - mask bit set after stacking, then vector high then vector low
// - one idle bus cycle then three program bytes fill the queue
// - upper index byte is never pushed on entry
// - software trap runs entry regardless of the mask bit
// - wait clears the mask bit and gates the cpu clocks
// - interrupt or reset wakes from wait and is processed normally
// - background command in wait restarts clocks into background mode
// - stop may keep minimal clocks so a periodic signal can wake
// - debug enable keeps oscillator in stop; background command wakes it
// - breakpoint opcode enters background; only reset or resume commands leave
// - no interrupt at the boundary right after a mask-clearing instruction
`timescale 1ns/1ns
`default_nettype none
module ces_seq
    import ces_pkg::*;
#(
    parameter logic [15:0] TRAP_VEC = 16'hfffc
)
(
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic        por_i,
    input  wire logic        wdog_rst_i,
    input  wire logic        rst_pin_b_i,
    input  wire logic        src_det_done_i,
    input  wire logic        ea_req_i,
    input  wire ces_am_t     ea_mode_i,
    input  wire logic [7:0]  op_hi_i,
    input  wire logic [7:0]  op_lo_i,
    input  wire logic [15:0] hx_i,
    input  wire logic [15:0] sp_i,
    input  wire logic        is_move_i,
    input  wire logic        is_compare_branch_equal_i,
    input  wire logic        insn_done_i,
    input  wire logic        clr_mask_insn_i,
    input  wire logic        trap_i,
    input  wire logic        wait_i,
    input  wire logic        stop_i,
    input  wire logic        bkpt_i,
    input  wire logic        irq_pend_i,
    input  wire logic [15:0] irq_vec_i,
    input  wire logic        mask_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [7:0]  acc_i,
    input  wire logic [7:0]  condition_code_reg_i,
    input  wire logic [7:0]  bus_rdata_i,
    input  wire logic        debug_enable_bit_i,
    input  wire logic        stop_keep_clk_i,
    input  wire logic        periodic_wake_i,
    input  wire logic        bg_entry_cmd_i,
    input  wire logic        go_cmd_i,
    input  wire logic        single_step_command_i,
    input  wire logic        tag_resume_command_i,
    output logic      [15:0] ea_o,
    output logic             ea_vld_o,
    output logic      [15:0] hx_o,
    output logic             hx_ld_o,
    output logic      [15:0] bus_addr_o,
    output logic      [7:0]  bus_wdata_o,
    output logic             bus_rd_o,
    output logic             bus_wr_o,
    output logic             set_mask_o,
    output logic             clr_mask_o,
    output logic      [15:0] pc_o,
    output logic             pc_ld_o,
    output logic      [15:0] sp_o,
    output logic             sp_ld_o,
    output logic             cpu_clk_en_o,
    output logic             osc_keep_o,
    output logic             min_clk_o,
    output logic             bdm_active_o,
    output logic             seq_busy_o
);

    typedef enum logic [3:0] {
        S_RST, S_RUN, S_STACK, S_VHI, S_VLO, S_FREE, S_FILL, S_WAIT, S_STOP, S_BDM
    } ces_state_t;

    // address former
    logic [15:0] ea_c;
    logic [15:0] hx_c;
    logic        hx_upd_c;
    logic [15:0] ea_reg,  ea_next;
    logic        ea_vld_reg, ea_vld_next;
    logic [15:0] hx_reg,  hx_next;
    logic        hx_ld_reg, hx_ld_next;

    ces_ea_calc u_ea (
        .mode_i    (ea_mode_i),
        .op_hi_i   (op_hi_i),
        .op_lo_i   (op_lo_i),
        .hx_i      (hx_i),
        .sp_i      (sp_i),
        .is_move_i (is_move_i),
        .is_compare_branch_equal_i (is_compare_branch_equal_i),
        .ea_o      (ea_c),
        .hx_new_o  (hx_c),
        .hx_upd_o  (hx_upd_c)
    );

    always_comb
    begin
        ea_next     = ea_reg;
        hx_next     = hx_reg;
        ea_vld_next = ea_req_i;
        hx_ld_next  = ea_req_i && hx_upd_c;
        if (ea_req_i)
        begin
            ea_next = ea_c;
            if (hx_upd_c)
                hx_next = hx_c;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            ea_reg     <= 16'h0000;
            ea_vld_reg <= 1'b0;
            hx_reg     <= 16'h0000;
            hx_ld_reg  <= 1'b0;
        end
        else
        begin
            ea_reg     <= ea_next;
            ea_vld_reg <= ea_vld_next;
            hx_reg     <= hx_next;
            hx_ld_reg  <= hx_ld_next;
        end
    end

    // exception sequencer
    ces_state_t  state_reg, state_next;
    logic [2:0]  cnt_reg,   cnt_next;
    logic [15:0] vec_reg,   vec_next;
    logic [15:0] sp_reg,    sp_next;
    logic [15:0] pc_reg,    pc_next;
    logic [15:0] addr_reg,  addr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        rd_reg, rd_next, wr_reg, wr_next;
    logic        smask_reg, smask_next, cmask_reg, cmask_next;
    logic        pcld_reg, pcld_next, spld_reg, spld_next;
    logic        clk_reg, clk_next, osc_reg, osc_next, minclk_reg, minclk_next;
    logic        bdm_reg, bdm_next, busy_reg, busy_next;
    logic        rst_evt, go_stack, resume;
    logic [15:0] go_vec;

    // the core holds pc, index, accumulator and condition codes still while busy
    function automatic logic [7:0] push_byte(input logic [2:0] idx);
        case (idx)
            3'h0:    return pc_i[7:0];
            3'h1:    return pc_i[15:8];
            3'h2:    return hx_i[7:0];
            3'h3:    return acc_i;
            default: return condition_code_reg_i;
        endcase
    endfunction

    assign rst_evt = por_i || wdog_rst_i || !rst_pin_b_i;
    assign resume  = go_cmd_i || single_step_command_i || tag_resume_command_i;

    always_comb
    begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        vec_next    = vec_reg;
        sp_next     = sp_reg;
        pc_next     = pc_reg;
        addr_next   = 16'h0000;
        wdata_next  = 8'h00;
        rd_next     = 1'b0;
        wr_next     = 1'b0;
        smask_next  = 1'b0;
        cmask_next  = 1'b0;
        pcld_next   = 1'b0;
        spld_next   = 1'b0;
        clk_next    = 1'b1;
        osc_next    = 1'b0;
        minclk_next = 1'b0;
        bdm_next    = 1'b0;
        go_stack    = 1'b0;
        go_vec      = irq_vec_i;
        if (rst_evt)
        begin
            state_next = S_RST;
            clk_next   = 1'b0;
        end
        else
        begin
            case (state_reg)
                S_RST:
                begin
                    clk_next = 1'b0;
                    if (src_det_done_i)
                    begin
                        state_next = S_VHI;
                        vec_next   = CES_RST_VEC_HI;
                        rd_next    = 1'b1;
                        addr_next  = CES_RST_VEC_HI;
                        clk_next   = 1'b1;
                    end
                end
                S_RUN:
                begin
                    if (insn_done_i)
                    begin
                        if (bkpt_i)
                        begin
                            state_next = S_BDM;
                            bdm_next   = 1'b1;
                        end
                        else if (trap_i)
                        begin
                            go_stack = 1'b1;
                            go_vec   = TRAP_VEC;
                        end
                        else if (wait_i)
                        begin
                            state_next = S_WAIT;
                            cmask_next = 1'b1;
                            clk_next   = 1'b0;
                        end
                        else if (stop_i)
                        begin
                            state_next  = S_STOP;
                            clk_next    = 1'b0;
                            osc_next    = debug_enable_bit_i;
                            minclk_next = stop_keep_clk_i;
                        end
                        else if (irq_pend_i && !mask_i && !clr_mask_insn_i)
                            go_stack = 1'b1;
                    end
                end
                S_STACK:
                begin
                    if (cnt_reg == CES_STACK_LAST)
                    begin
                        smask_next = 1'b1;
                        spld_next  = 1'b1;
                        state_next = S_VHI;
                        rd_next    = 1'b1;
                        addr_next  = vec_reg;
                    end
                    else
                    begin
                        cnt_next   = 3'(cnt_reg + 3'h1);
                        wr_next    = 1'b1;
                        addr_next  = sp_reg;
                        wdata_next = push_byte(3'(cnt_reg + 3'h1));
                        sp_next    = 16'(sp_reg - CES_SP_DEC);
                    end
                end
                S_VHI:
                begin
                    pc_next[15:8] = bus_rdata_i;
                    state_next    = S_VLO;
                    rd_next       = 1'b1;
                    addr_next     = 16'(vec_reg + 16'h0001);
                end
                S_VLO:
                begin
                    pc_next[7:0] = bus_rdata_i;
                    state_next   = S_FREE;
                end
                S_FREE:
                begin
                    state_next = S_FILL;
                    cnt_next   = 3'h0;
                    rd_next    = 1'b1;
                    addr_next  = pc_reg;
                end
                S_FILL:
                begin
                    if (cnt_reg[1:0] == CES_FILL_LAST)
                    begin
                        state_next = S_RUN;
                        pcld_next  = 1'b1;
                    end
                    else
                    begin
                        cnt_next  = 3'(cnt_reg + 3'h1);
                        rd_next   = 1'b1;
                        addr_next = 16'(pc_reg + {13'h0000, cnt_reg} + 16'h0001);
                    end
                end
                S_WAIT:
                begin
                    clk_next = 1'b0;
                    if (irq_pend_i)
                        go_stack = 1'b1;
                    else if (bg_entry_cmd_i)
                    begin
                        state_next = S_BDM;
                        bdm_next   = 1'b1;
                        clk_next   = 1'b1;
                    end
                end
                S_STOP:
                begin
                    clk_next    = 1'b0;
                    osc_next    = debug_enable_bit_i;
                    minclk_next = stop_keep_clk_i;
                    if (bg_entry_cmd_i && debug_enable_bit_i)
                    begin
                        state_next = S_BDM;
                        bdm_next   = 1'b1;
                        clk_next   = 1'b1;
                        osc_next   = 1'b0;
                        minclk_next = 1'b0;
                    end
                    else if (periodic_wake_i && stop_keep_clk_i)
                    begin
                        go_stack    = 1'b1;
                        osc_next    = 1'b0;
                        minclk_next = 1'b0;
                    end
                end
                S_BDM:
                begin
                    bdm_next = 1'b1;
                    if (resume)
                    begin
                        state_next = S_RUN;
                        bdm_next   = 1'b0;
                    end
                end
                default:
                begin
                    state_next = S_RST;
                    clk_next   = 1'b0;
                end
            endcase
            if (go_stack)
            begin
                state_next = S_STACK;
                clk_next   = 1'b1;
                cnt_next   = 3'h0;
                vec_next   = go_vec;
                wr_next    = 1'b1;
                addr_next  = sp_i;
                wdata_next = push_byte(3'h0);
                sp_next    = 16'(sp_i - CES_SP_DEC);
            end
        end
        busy_next = (state_next != S_RUN);
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            state_reg  <= S_RST;
            cnt_reg    <= 3'h0;
            vec_reg    <= 16'h0000;
            sp_reg     <= 16'h0000;
            pc_reg     <= 16'h0000;
            addr_reg   <= 16'h0000;
            wdata_reg  <= 8'h00;
            rd_reg     <= 1'b0;
            wr_reg     <= 1'b0;
            smask_reg  <= 1'b0;
            cmask_reg  <= 1'b0;
            pcld_reg   <= 1'b0;
            spld_reg   <= 1'b0;
            clk_reg    <= 1'b0;
            osc_reg    <= 1'b0;
            minclk_reg <= 1'b0;
            bdm_reg    <= 1'b0;
            busy_reg   <= 1'b1;
        end
        else
        begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            vec_reg    <= vec_next;
            sp_reg     <= sp_next;
            pc_reg     <= pc_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            rd_reg     <= rd_next;
            wr_reg     <= wr_next;
            smask_reg  <= smask_next;
            cmask_reg  <= cmask_next;
            pcld_reg   <= pcld_next;
            spld_reg   <= spld_next;
            clk_reg    <= clk_next;
            osc_reg    <= osc_next;
            minclk_reg <= minclk_next;
            bdm_reg    <= bdm_next;
            busy_reg   <= busy_next;
        end
    end

    assign ea_o         = ea_reg;
    assign ea_vld_o     = ea_vld_reg;
    assign hx_o         = hx_reg;
    assign hx_ld_o      = hx_ld_reg;
    assign bus_addr_o   = addr_reg;
    assign bus_wdata_o  = wdata_reg;
    assign bus_rd_o     = rd_reg;
    assign bus_wr_o     = wr_reg;
    assign set_mask_o   = smask_reg;
    assign clr_mask_o   = cmask_reg;
    assign pc_o         = pc_reg;
    assign pc_ld_o      = pcld_reg;
    assign sp_o         = sp_reg;
    assign sp_ld_o      = spld_reg;
    assign cpu_clk_en_o = clk_reg;
    assign osc_keep_o   = osc_reg;
    assign min_clk_o    = minclk_reg;
    assign bdm_active_o = bdm_reg;
    assign seq_busy_o   = busy_reg;

    logic run_bnd;
    assign run_bnd = (state_reg == S_RUN) && insn_done_i && !rst_evt && !bkpt_i;

    property p_dir;
        @(posedge mclk_i) disable iff (!rst_b_i)
        ea_req_i && ea_mode_i == CES_AM_DIR |=> ea_o == {8'h00, $past(op_lo_i)} && ea_vld_o;
    endproperty
    a_dir: assert property (p_dir) else $error("direct address wrong");
    property p_ext;
        @(posedge mclk_i) disable iff (!rst_b_i)
        ea_req_i && ea_mode_i == CES_AM_EXT |=> ea_o == {$past(op_hi_i), $past(op_lo_i)};
    endproperty
    a_ext: assert property (p_ext) else $error("extended address wrong");
    property p_ix1;
        @(posedge mclk_i) disable iff (!rst_b_i)
        ea_req_i && ea_mode_i == CES_AM_IX1
            |=> ea_o == 16'($past(hx_i) + {8'h00, $past(op_lo_i)});
    endproperty
    a_ix1: assert property (p_ix1) else $error("indexed offset address wrong");
    property p_sp2;
        @(posedge mclk_i) disable iff (!rst_b_i)
        ea_req_i && ea_mode_i == CES_AM_SP2
            |=> ea_o == 16'($past(sp_i) + {$past(op_hi_i), $past(op_lo_i)});
    endproperty
    a_sp2: assert property (p_sp2) else $error("stack offset address wrong");
    property p_pinc;
        @(posedge mclk_i) disable iff (!rst_b_i)
        ea_req_i && ea_mode_i == CES_AM_IXP && !is_move_i && !is_compare_branch_equal_i
            |=> !hx_ld_o;
    endproperty
    a_pinc: assert property (p_pinc) else $error("post increment on wrong insn");
    property p_abort;
        @(posedge mclk_i) disable iff (!rst_b_i)
        rst_evt |=> !cpu_clk_en_o && !bus_wr_o && !bus_rd_o && seq_busy_o;
    endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort");
    property p_rstseq;
        @(posedge mclk_i) disable iff (!rst_b_i || rst_evt)
        state_reg == S_RST && src_det_done_i |=> bus_rd_o && bus_addr_o == CES_RST_VEC_HI
            ##1 bus_addr_o == CES_RST_VEC_LO ##1 !bus_rd_o ##1 bus_rd_o [*3] ##1 pc_ld_o;
    endproperty
    a_rstseq: assert property (p_rstseq) else $error("reset vector sequence wrong");
    property p_trap;
        @(posedge mclk_i) disable iff (!rst_b_i || rst_evt)
        run_bnd && trap_i |=> bus_wr_o && bus_wdata_o == $past(pc_i[7:0])
            ##1 bus_wr_o [*4] ##1 set_mask_o && bus_rd_o && bus_addr_o == TRAP_VEC;
    endproperty
    a_trap: assert property (p_trap) else $error("trap entry sequence wrong");
    property p_inhibit;
        @(posedge mclk_i) disable iff (!rst_b_i)
        run_bnd && clr_mask_insn_i && !trap_i |=> !bus_wr_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("irq taken after mask clear");
    property p_wait;
        @(posedge mclk_i) disable iff (!rst_b_i)
        run_bnd && !trap_i && wait_i |=> clr_mask_o && !cpu_clk_en_o;
    endproperty
    a_wait: assert property (p_wait) else $error("wait entry wrong");
    property p_bdm;
        @(posedge mclk_i) disable iff (!rst_b_i)
        bdm_active_o && !resume && !rst_evt |=> bdm_active_o;
    endproperty
    a_bdm: assert property (p_bdm) else $error("left background mode early");

    c_rst: cover property (@(posedge mclk_i) state_reg == S_RST ##1 state_reg == S_VHI);
    c_irq: cover property (@(posedge mclk_i) run_bnd && irq_pend_i && !mask_i ##1 bus_wr_o);
    c_wake: cover property (@(posedge mclk_i) state_reg == S_WAIT ##1 state_reg == S_STACK);
    c_bdm: cover property (@(posedge mclk_i) state_reg == S_STOP ##1 bdm_active_o);

endmodule
`default_nettype wire

// ===== hw/ces_pkg.sv
package ces_pkg;

    // operand addressing modes
    typedef enum logic [3:0] {
        CES_AM_DIR,
        CES_AM_EXT,
        CES_AM_IX,
        CES_AM_IXP,
        CES_AM_IX1,
        CES_AM_IX1P,
        CES_AM_IX2,
        CES_AM_SP1,
        CES_AM_SP2
    } ces_am_t;

    localparam logic [7:0]  CES_DIR_PAGE    = 8'h00;
    localparam logic [15:0] CES_IDX_INC     = 16'h0001;
    localparam logic [15:0] CES_RST_VEC_HI  = 16'hfffe;
    localparam logic [15:0] CES_RST_VEC_LO  = 16'hffff;
    localparam logic [15:0] CES_SP_DEC      = 16'h0001;
    localparam logic [2:0]  CES_STACK_LAST  = 3'h4;
    localparam logic [1:0]  CES_FILL_LAST   = 2'h2;
    localparam int          CES_RST_SEQ_CYC = 6;

    function automatic logic ces_is_post_inc(input ces_am_t m);
        return (m == CES_AM_IXP) || (m == CES_AM_IX1P);
    endfunction

endpackage

// ===== hw/ces_ea_calc.sv
`timescale 1ns/1ns
`default_nettype none
module ces_ea_calc
    import ces_pkg::*;
(
    input  wire ces_am_t     mode_i,
    input  wire logic [7:0]  op_hi_i,
    input  wire logic [7:0]  op_lo_i,
    input  wire logic [15:0] hx_i,
    input  wire logic [15:0] sp_i,
    input  wire logic        is_move_i,
    input  wire logic        is_compare_branch_equal_i,
    output logic      [15:0] ea_o,
    output logic      [15:0] hx_new_o,
    output logic             hx_upd_o
);

    logic [15:0] off8;
    logic [15:0] off16;

    assign off8  = {8'h00, op_lo_i};
    assign off16 = {op_hi_i, op_lo_i};

    // all sums wrap at 16 bits
    always_comb
    begin
        case (mode_i)
            CES_AM_DIR:  ea_o = {CES_DIR_PAGE, op_lo_i};
            CES_AM_EXT:  ea_o = off16;
            CES_AM_IX,
            CES_AM_IXP:  ea_o = hx_i;
            CES_AM_IX1,
            CES_AM_IX1P: ea_o = 16'(hx_i + off8);
            CES_AM_IX2:  ea_o = 16'(hx_i + off16);
            CES_AM_SP1:  ea_o = 16'(sp_i + off8);
            CES_AM_SP2:  ea_o = 16'(sp_i + off16);
            default:     ea_o = 16'h0000;
        endcase
    end

    assign hx_new_o = 16'(hx_i + CES_IDX_INC);
    // post increment only decoded for the instructions that own it
    assign hx_upd_o = ((mode_i == CES_AM_IXP) && (is_move_i || is_compare_branch_equal_i))
                    || ((mode_i == CES_AM_IX1P) && is_compare_branch_equal_i);

endmodule
`default_nettype wire

// ===== dv/ces_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// memory behind the sequencer's bus
module ces_mem_model (
    input  wire logic        mclk_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o
);
    logic [7:0] last_reg = 8'h00;
    // idle bus shows a changing pattern so a late sample never matches
    assign rdata_o = rd_i ? (addr_i[7:0] ^ addr_i[15:8] ^ 8'h3c) : ~last_reg;
    always @(posedge mclk_i) last_reg <= rdata_o;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ces_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH %0t %h vs %h", $time, a, b); end end
    localparam logic [15:0] TV = 16'hfff8;
    logic mclk_i = 0, rst_b_i = 0, por_i = 0, wdog_rst_i = 0, rst_pin_b_i = 1, ea_req_i = 0;
    logic src_det_done_i = 0, is_move_i = 0, insn_done_i = 0, trap_i = 0;
    logic is_compare_branch_equal_i = 0;
    logic clr_mask_insn_i = 0, wait_i = 0, stop_i = 0, bkpt_i = 0, irq_pend_i = 0, mask_i = 0;
    logic debug_enable_bit_i = 0, stop_keep_clk_i = 0, periodic_wake_i = 0, bg_entry_cmd_i = 0;
    logic go_cmd_i = 0, single_step_command_i = 0, tag_resume_command_i = 0;
    logic [7:0] op_hi_i = 0, op_lo_i = 0, acc_i = 0, bus_rdata_i, bus_wdata_o, wd[5];
    logic [7:0] condition_code_reg_i = 0;
    logic [15:0] hx_i = 0, sp_i = 0, irq_vec_i = 0, pc_i = 0, ea_o, hx_o, bus_addr_o, pc_o, sp_o, t;
    ces_am_t ea_mode_i = CES_AM_DIR;
    logic ea_vld_o, hx_ld_o, bus_rd_o, bus_wr_o, set_mask_o, clr_mask_o, pc_ld_o, sp_ld_o;
    logic cpu_clk_en_o, osc_keep_o, min_clk_o, bdm_active_o, seq_busy_o, hl;
    int err_count = 0, checked = 0, cyc = 0, sm = 0;
    logic [32:0] log_q[$];
    ces_seq #(.TRAP_VEC(TV)) ces_seq_inst (.*);
    ces_mem_model ces_mem_model_inst (.mclk_i(mclk_i), .addr_i(bus_addr_o), .rd_i(bus_rd_o),
                                      .rdata_o(bus_rdata_i));
    initial forever #20 mclk_i = ~mclk_i;
    // bus log: cycle stamp, write flag, address, data
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        sm <= sm + int'(set_mask_o === 1'b1) + 2 * int'(sp_ld_o === 1'b1);
        if (bus_rd_o | bus_wr_o)
            log_q.push_back({cyc[7:0], bus_wr_o, bus_addr_o, bus_wr_o ? bus_wdata_o : bus_rdata_i});
    end
    function automatic logic [7:0] md(logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [15:0] ea_exp;
        logic [15:0] b;
        b = ea_mode_i inside {CES_AM_SP1, CES_AM_SP2} ? sp_i : hx_i;
        case (ea_mode_i)
            CES_AM_DIR: return {8'h00, op_lo_i};
            CES_AM_EXT: return {op_hi_i, op_lo_i};
            CES_AM_IX, CES_AM_IXP: return hx_i;
            CES_AM_IX2, CES_AM_SP2: return b + {op_hi_i, op_lo_i};
            default: return b + {8'h00, op_lo_i};
        endcase
    endfunction
    task automatic tk(int k = 1);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tk();
        s = 0;
    endtask
    task automatic stop_test;
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // nw pushes, two vector reads, one idle cycle, three fills
    task automatic chk_seq(int nw, logic [15:0] v);
        logic [7:0] c0;
        for (int n = 0; n < 60 && seq_busy_o !== 1'b0; n++) tk();
        `CHK({seq_busy_o, pc_ld_o}, 2'h1)
        `CHK(log_q.size(), nw + 5)
        c0 = log_q[0][32:25];
        for (int i = 0; i < nw + 5 && i < log_q.size(); i++)
        begin
            t = i < nw ? sp_i - i : i < nw + 2 ? v + (i - nw) : {md(v), md(v + 16'h1)} + (i - nw - 2);
            `CHK(log_q[i][24:8], {1'(i < nw), t})
            `CHK(log_q[i][32:25] - c0, 8'(i < nw + 2 ? i : i + 1))
            if (i < nw) `CHK(log_q[i][7:0], wd[i])
        end
        `CHK(pc_o, {md(v), md(v + 16'h1)})
    endtask
    task automatic ent(logic p, logic [15:0] v);
        int s0;
        s0 = sm;
        log_q.delete();
        wd = '{pc_i[7:0], pc_i[15:8], hx_i[7:0], acc_i, condition_code_reg_i};
        if (p) insn_done_i = 1'b1;
        tk();
        {insn_done_i, trap_i, irq_pend_i, periodic_wake_i} = 4'h0;
        chk_seq(5, v);
        `CHK(sp_o, sp_i - 16'h5)
        `CHK(sm - s0, 3)
    endtask
    task automatic boot;
        {rst_pin_b_i, src_det_done_i} = 2'h0;
        log_q.delete();
        tk(4);
        rst_pin_b_i = 1;
        tk(4);
        `CHK({seq_busy_o, 8'(log_q.size())}, 9'h100)
        src_det_done_i = 1;
        chk_seq(0, 16'hfffe);
    endtask
    initial
    begin
        void'($urandom(76067));
        tk(16);
        rst_b_i = 1;
        boot();
        ea_req_i = 1;
        for (int i = 0; i < 60; i++)
        begin
            ea_mode_i = ces_am_t'($urandom % 9);
            {op_hi_i, op_lo_i, is_move_i, is_compare_branch_equal_i, sp_i} =
                34'({$urandom, $urandom});
            hx_i = i % 4 ? 16'($urandom) : 16'hffff;
            tk();
            `CHK({ea_vld_o, ea_o}, {1'b1, ea_exp()})
            hl = ea_mode_i == CES_AM_IXP && (is_move_i | is_compare_branch_equal_i);
            hl |= ea_mode_i == CES_AM_IX1P && is_compare_branch_equal_i;
            `CHK(hx_ld_o, hl)
            if (hx_ld_o === 1'b1) `CHK(hx_o, hx_i + 16'h1)
        end
        ea_req_i = 0;
        {pc_i, acc_i, condition_code_reg_i, irq_vec_i} = {$urandom, 16'($urandom)};
        {mask_i, trap_i} = 2'h3;
        ent(1, TV);
        {mask_i, irq_pend_i, clr_mask_insn_i} = 3'h3;
        pulse(insn_done_i);
        clr_mask_insn_i = 0;
        tk();
        `CHK(seq_busy_o, 1'b0)
        ent(1, irq_vec_i);
        for (int k = 0; k < 2; k++)
        begin
            trap_i = 1;
            pulse(insn_done_i);
            trap_i = 0;
            tk(2);
            if (k == 0) pulse(por_i);
            else pulse(wdog_rst_i);
            boot();
        end
        for (int k = 0; k < 2; k++)
        begin
            wait_i = 1;
            pulse(insn_done_i);
            wait_i = 0;
            `CHK({clr_mask_o, cpu_clk_en_o}, 2'h2)
            irq_pend_i = !k;
            if (k == 0) ent(0, irq_vec_i);
            else pulse(bg_entry_cmd_i);
            `CHK({cpu_clk_en_o, bdm_active_o}, {1'b1, 1'(k)})
            if (k) pulse(go_cmd_i);
        end
        for (int k = 0; k < 3; k++)
        begin
            bkpt_i = 1;
            pulse(insn_done_i);
            bkpt_i = 0;
            tk(2);
            `CHK(bdm_active_o, 1'b1)
            if (k == 0) pulse(go_cmd_i);
            else if (k == 1) pulse(single_step_command_i);
            else pulse(tag_resume_command_i);
            `CHK(bdm_active_o, 1'b0)
        end
        for (int k = 0; k < 4; k++)
        begin
            {debug_enable_bit_i, stop_keep_clk_i} = 2'(k);
            stop_i = 1;
            pulse(insn_done_i);
            stop_i = 0;
            `CHK({cpu_clk_en_o, osc_keep_o, min_clk_o}, {1'b0, 2'(k)})
            periodic_wake_i = k == 1;
            if (k == 1) ent(0, irq_vec_i);
            else pulse(bg_entry_cmd_i);
            `CHK(bdm_active_o, debug_enable_bit_i)
            if (k > 1) pulse(go_cmd_i);
            if (k == 0) boot();
        end
        stop_test();
    end
    initial
    begin
        #1000000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
